//--- monitor_pkg.sv
`default_nettype none
package monitor_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_SHUNT = 8'h01;
	localparam logic [7:0] REG_BUS = 8'h02;
	localparam logic [7:0] REG_POWER = 8'h03;
	localparam logic [7:0] REG_CURRENT = 8'h04;
	localparam logic [7:0] REG_CAL = 8'h05;
	localparam logic [7:0] REG_MASK = 8'h06;
	localparam logic [7:0] REG_LIMIT = 8'h07;
	localparam logic [15:0] CONFIG_RESET = 16'h0007;
	localparam logic [15:0] CONFIG_WMASK = 16'h7fff;
	localparam int AVG_LSB = 9;
	localparam int BUS_CT_LSB = 6;
	localparam int SHUNT_CT_LSB = 3;
	// mode code bits
	localparam int MODE_SHUNT = 0;
	localparam int MODE_BUS = 1;
	localparam int MODE_CONT = 2;
	// alert_mask_enable layout
	localparam int EN_LSB = 10;
	localparam int LIMIT_FLAG_BIT = 4;
	localparam int READY_FLAG_BIT = 3;
	localparam int POLARITY_BIT = 1;
	localparam int LEN_BIT = 0;
	// index inside the six-bit enable field
	localparam int EN_SHUNT_OVER = 5;
	localparam int EN_SHUNT_UNDER = 4;
	localparam int EN_BUS_OVER = 3;
	localparam int EN_BUS_UNDER = 2;
	localparam int EN_POWER_OVER = 1;
	localparam int EN_READY = 0;
	// ---------------------------------------------------------------
	// timing and arithmetic
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int RECOVER_NS = 40000;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] RECOVER_LOAD = 9'(RECOVER_CYC - 1);
	localparam int CAL_SHIFT = 11;
	localparam int POWER_LSB_RATIO = 25;
	localparam int BUS_LSB_UV = 1250;
	localparam logic [31:0] POWER_DIV = 32'(POWER_LSB_RATIO * 1000000 / BUS_LSB_UV);

	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		case (code)
			3'h0: return 4'h0;
			3'h1: return 4'h2;
			3'h2: return 4'h4;
			3'h3: return 4'h6;
			3'h4: return 4'h7;
			3'h5: return 4'h8;
			3'h6: return 4'h9;
			default: return 4'ha;
		endcase
	endfunction : avg_shift

	function automatic logic [10:0] avg_count(input logic [2:0] code);
		return 11'h001 << avg_shift(code);
	endfunction : avg_count

	function automatic logic [15:0] average(input logic [31:0] sum, input logic [2:0] code);
		logic signed [31:0] q;
		q = $signed(sum) >>> avg_shift(code);
		return q[15:0];
	endfunction : average

	function automatic logic [31:0] sext(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction : sext
endpackage : monitor_pkg
`default_nettype wire

//--- reg_link.sv
`timescale 1ns/10ps
`default_nettype none
// link-side request port; words stay stable until the core toggles back
module reg_link (
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	output logic xfer_toggle,
	output logic xfer_write,
	output logic [7:0] xfer_addr,
	output logic [15:0] xfer_wdata,
	input wire logic done_toggle,
	input wire logic [15:0] done_rdata
);
	typedef struct packed {
		logic busy;
		logic tog;
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic d_s1;
		logic d_s2;
		logic d_seen;
		logic rvalid;
		logic [15:0] rdata;
	} link_state_t;

	link_state_t s, n;

	always_comb begin
		n = s;
		n.rvalid = 1'b0;
		n.d_s1 = done_toggle;
		n.d_s2 = s.d_s1;
		if (!s.busy && req_valid) begin
			n.busy = 1'b1;
			n.tog = ~s.tog;
			n.wr = req_write;
			n.addr = req_addr;
			n.wdata = req_wdata;
		end
		if (s.busy && s.d_s2 != s.d_seen) begin
			n.busy = 1'b0;
			n.d_seen = s.d_s2;
			n.rvalid = ~s.wr;
			n.rdata = done_rdata;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst)
			s <= '0;
		else
			s <= n;
	end

	assign req_ready = ~s.busy;
	assign rsp_valid = s.rvalid;
	assign rsp_rdata = s.rdata;
	assign xfer_toggle = s.tog;
	assign xfer_write = s.wr;
	assign xfer_addr = s.addr;
	assign xfer_wdata = s.wdata;
endmodule : reg_link
`default_nettype wire

//--- monitor_core.sv
`timescale 1ns/10ps
`default_nettype none
module monitor_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	output logic conv_start,
	output logic conv_chan,
	output logic [2:0] conv_time,
	output logic front_end_on,
	output logic alert_o,
	output logic alert_oe
);
	typedef enum logic [2:0] {S_DOWN, S_WAKE, S_IDLE, S_SHUNT, S_BUS} seq_state_t;

	typedef struct packed {
		seq_state_t state;
		logic tog_s1;
		logic tog_s2;
		logic tog_seen;
		logic done_tog;
		logic [15:0] rdata;
		logic [15:0] config_r;
		logic [15:0] cal;
		logic [5:0] en;
		logic alert_polarity_select;
		logic len;
		logic [15:0] limit;
		logic [15:0] shunt_out;
		logic [15:0] bus_out;
		logic [15:0] cur_out;
		logic [15:0] pwr_out;
		logic [31:0] acc_shunt;
		logic [31:0] acc_bus;
		logic [31:0] acc_cur;
		logic [31:0] acc_pwr;
		logic [10:0] samp_cnt;
		logic [15:0] cur_last;
		logic [8:0] recover;
		logic conversion_ready_flag;
		logic limit_function_flag;
		logic start;
		logic chan;
		logic [2:0] ctime;
		logic fe_on;
		logic alert_lvl;
		logic alert_en;
	} core_state_t;

	core_state_t s, n;
	logic xfer_toggle, xfer_write;
	logic [7:0] xfer_addr;
	logic [15:0] xfer_wdata;

	// ---------------------------------------------------------------
	// link side, crossed by toggle handshake
	// ---------------------------------------------------------------
	reg_link u_link (
		.link_clk(link_clk),
		.link_rst(link_rst),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.xfer_toggle(xfer_toggle),
		.xfer_write(xfer_write),
		.xfer_addr(xfer_addr),
		.xfer_wdata(xfer_wdata),
		.done_toggle(s.done_tog),
		.done_rdata(s.rdata)
	);

	// ---------------------------------------------------------------
	// background arithmetic
	// ---------------------------------------------------------------
	function automatic logic [15:0] calc_current(input logic [15:0] shunt, input logic [15:0] cal);
		logic signed [32:0] p;
		p = 33'($signed(shunt) * $signed({1'b0, cal}));
		p = p >>> monitor_pkg::CAL_SHIFT;
		return p[15:0];
	endfunction : calc_current

	function automatic logic [15:0] calc_power(input logic [15:0] cur, input logic [15:0] bus);
		logic [15:0] mag;
		logic [31:0] p;
		mag = cur[15] ? 16'(-cur) : cur;
		p = ({16'h0000, mag} * {16'h0000, bus}) / monitor_pkg::POWER_DIV;
		return p[15:0];
	endfunction : calc_power

	logic acc_go, cfg_wr, mask_rd, shunt_done, bus_done, set_done, last, load;
	logic start_req, start_chan, viol, cmp_evt, cal_zero;
	logic [2:0] mode, new_mode, avg_code;
	logic [15:0] cur_now, pwr_now;
	logic [31:0] sum_s, sum_b, sum_c, sum_p;

	always_comb begin
		n = s;
		n.start = 1'b0;
		n.tog_s1 = xfer_toggle;
		n.tog_s2 = s.tog_s1;
		acc_go = s.tog_s2 != s.tog_seen;
		cfg_wr = acc_go && xfer_write && xfer_addr == monitor_pkg::REG_CONFIG;
		mask_rd = acc_go && !xfer_write && xfer_addr == monitor_pkg::REG_MASK;
		mode = s.config_r[2:0];
		avg_code = s.config_r[monitor_pkg::AVG_LSB +: 3];
		new_mode = xfer_wdata[2:0];
		shunt_done = conv_done && s.state == S_SHUNT;
		bus_done = conv_done && s.state == S_BUS;
		cal_zero = s.cal == 16'h0000;
		cur_now = cal_zero ? 16'h0000 : calc_current(conv_data, s.cal);
		pwr_now = cal_zero ? 16'h0000 : calc_power(s.cur_last, conv_data);
		sum_s = s.acc_shunt + (shunt_done ? monitor_pkg::sext(conv_data) : 32'h0);
		sum_c = s.acc_cur + (shunt_done ? monitor_pkg::sext(cur_now) : 32'h0);
		sum_b = s.acc_bus + (bus_done ? {16'h0000, conv_data} : 32'h0);
		sum_p = s.acc_pwr + (bus_done ? {16'h0000, pwr_now} : 32'h0);
		set_done = (shunt_done && !mode[monitor_pkg::MODE_BUS]) || bus_done;
		last = s.samp_cnt + 11'h001 == monitor_pkg::avg_count(avg_code);
		load = set_done && last;
		start_req = 1'b0;
		start_chan = !mode[monitor_pkg::MODE_SHUNT];
		// -----------------------------------------------------------
		// register access; reads have no side path into the sequencer
		// -----------------------------------------------------------
		if (acc_go) begin
			n.tog_seen = s.tog_s2;
			n.done_tog = ~s.done_tog;
			if (xfer_write) begin
				unique case (xfer_addr)
					monitor_pkg::REG_CONFIG: n.config_r = xfer_wdata & monitor_pkg::CONFIG_WMASK;
					monitor_pkg::REG_CAL: n.cal = xfer_wdata;
					monitor_pkg::REG_MASK: begin
						n.en = xfer_wdata[monitor_pkg::EN_LSB +: 6];
						n.alert_polarity_select = xfer_wdata[monitor_pkg::POLARITY_BIT];
						n.len = xfer_wdata[monitor_pkg::LEN_BIT];
					end
					monitor_pkg::REG_LIMIT: n.limit = xfer_wdata;
					default: ;
				endcase
			end else begin
				unique case (xfer_addr)
					monitor_pkg::REG_CONFIG: n.rdata = s.config_r;
					monitor_pkg::REG_SHUNT: n.rdata = s.shunt_out;
					monitor_pkg::REG_BUS: n.rdata = s.bus_out;
					monitor_pkg::REG_POWER: n.rdata = s.pwr_out;
					monitor_pkg::REG_CURRENT: n.rdata = s.cur_out;
					monitor_pkg::REG_CAL: n.rdata = s.cal;
					monitor_pkg::REG_MASK: n.rdata = {s.en, 5'h00, s.limit_function_flag,
						s.conversion_ready_flag, 1'b0, s.alert_polarity_select, s.len};
					monitor_pkg::REG_LIMIT: n.rdata = s.limit;
					default: n.rdata = 16'h0000;
				endcase
			end
		end
		// clears go first so that a same-cycle event wins
		if ((cfg_wr && new_mode[1:0] != 2'b00) || mask_rd)
			n.conversion_ready_flag = 1'b0;
		if (cfg_wr || mask_rd)
			n.limit_function_flag = 1'b0;
		// -----------------------------------------------------------
		// conversion sequencer
		// -----------------------------------------------------------
		unique case (s.state)
			S_DOWN, S_IDLE: ;
			S_WAKE: begin
				if (s.recover == 9'h000)
					start_req = 1'b1;
				else
					n.recover = s.recover - 9'h001;
			end
			S_SHUNT: begin
				if (shunt_done) begin
					n.cur_last = cur_now;
					n.acc_shunt = sum_s;
					n.acc_cur = sum_c;
					if (mode[monitor_pkg::MODE_BUS]) begin
						start_req = 1'b1;
						start_chan = 1'b1;
					end
				end
			end
			S_BUS: begin
				if (bus_done) begin
					n.acc_bus = sum_b;
					n.acc_pwr = sum_p;
				end
			end
		endcase
		if (set_done) begin
			if (last) begin
				if (mode[monitor_pkg::MODE_SHUNT]) begin
					n.shunt_out = monitor_pkg::average(sum_s, avg_code);
					n.cur_out = monitor_pkg::average(sum_c, avg_code);
				end
				if (mode[monitor_pkg::MODE_BUS]) begin
					n.bus_out = monitor_pkg::average(sum_b, avg_code);
					n.pwr_out = monitor_pkg::average(sum_p, avg_code);
				end
				n.acc_shunt = 32'h0;
				n.acc_bus = 32'h0;
				n.acc_cur = 32'h0;
				n.acc_pwr = 32'h0;
				n.samp_cnt = 11'h000;
				n.conversion_ready_flag = 1'b1;
			end else begin
				n.samp_cnt = s.samp_cnt + 11'h001;
			end
			if (!last || mode[monitor_pkg::MODE_CONT])
				start_req = 1'b1;
			else
				n.state = S_IDLE;
		end
		// -----------------------------------------------------------
		// limit compare against raw shunt and bus samples and the computed power
		// -----------------------------------------------------------
		viol = 1'b0;
		cmp_evt = 1'b0;
		if (s.en[monitor_pkg::EN_SHUNT_OVER]) begin
			cmp_evt = shunt_done;
			viol = $signed(conv_data) > $signed(s.limit);
		end else if (s.en[monitor_pkg::EN_SHUNT_UNDER]) begin
			cmp_evt = shunt_done;
			viol = $signed(conv_data) < $signed(s.limit);
		end else if (s.en[monitor_pkg::EN_BUS_OVER]) begin
			cmp_evt = bus_done;
			viol = conv_data > s.limit;
		end else if (s.en[monitor_pkg::EN_BUS_UNDER]) begin
			cmp_evt = bus_done;
			viol = conv_data < s.limit;
		end else if (s.en[monitor_pkg::EN_POWER_OVER]) begin
			cmp_evt = bus_done;
			viol = pwr_now > s.limit;
		end
		if (cmp_evt && viol)
			n.limit_function_flag = 1'b1;
		else if (cmp_evt && !s.len)
			n.limit_function_flag = 1'b0;
		if (start_req) begin
			n.start = 1'b1;
			n.chan = start_chan;
			n.state = start_chan ? S_BUS : S_SHUNT;
		end
		// config write restarts the set, or powers down when mode bits 1:0 are zero; the sequence is otherwise untouched by host traffic
		if (cfg_wr) begin
			n.acc_shunt = 32'h0;
			n.acc_bus = 32'h0;
			n.acc_cur = 32'h0;
			n.acc_pwr = 32'h0;
			n.samp_cnt = 11'h000;
			if (new_mode[1:0] == 2'b00) begin
				n.start = 1'b0;
				n.state = S_DOWN;
			end else if (s.state == S_DOWN) begin
				n.start = 1'b0;
				n.recover = monitor_pkg::RECOVER_LOAD;
				n.state = S_WAKE;
			end else begin
				n.start = 1'b1;
				n.chan = !new_mode[monitor_pkg::MODE_SHUNT];
				n.state = n.chan ? S_BUS : S_SHUNT;
			end
		end
		n.ctime = n.chan ? n.config_r[monitor_pkg::BUS_CT_LSB +: 3] :
			n.config_r[monitor_pkg::SHUNT_CT_LSB +: 3];
		n.fe_on = n.state != S_DOWN;
		n.alert_lvl = 1'b0;
		// open drain: pull low whenever the pin should read low
		n.alert_en = (n.limit_function_flag | (n.en[monitor_pkg::EN_READY] &
			n.conversion_ready_flag)) ^ n.alert_polarity_select;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.state <= S_IDLE;
			s.config_r <= monitor_pkg::CONFIG_RESET;
			s.fe_on <= 1'b1;
			s.alert_en <= 1'b0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign conv_start = s.start;
	assign conv_chan = s.chan;
	assign conv_time = s.ctime;
	assign front_end_on = s.fe_on;
	assign alert_o = s.alert_lvl;
	assign alert_oe = s.alert_en;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_cont_restart: assert property (ce && bus_done && !cfg_wr && mode == 3'h7 |=>
		s.start && !s.chan) else $error("continuous mode did not restart");
	a_current_zero: assert property (ce && shunt_done && cal_zero |=>
		s.cur_last == 16'h0000) else $error("current not zero without calibration");
	a_output_hold: assert property (ce && !load |=> $stable(s.shunt_out) &&
		$stable(s.pwr_out)) else $error("output changed without a finished set");
	a_ready_set: assert property (ce && load |=> s.conversion_ready_flag)
		else $error("ready not set");
	a_ready_clear: assert property (ce && mask_rd && !load |=> !s.conversion_ready_flag)
		else $error("ready not cleared by mask read");
	a_single_shot: assert property (ce && load && !cfg_wr && !mode[2] |=>
		s.state == S_IDLE ##1 !s.start) else $error("single shot ran again");
	a_wake_quiet: assert property (s.state == S_WAKE |-> !s.start)
		else $error("conversion during recovery");
	a_down_quiet: assert property (s.state == S_DOWN |-> !s.start && !s.fe_on)
		else $error("conversion in power-down");
	a_alert_level: assert property (ce && cmp_evt && viol |=>
		s.alert_en != s.alert_polarity_select) else $error("alert pin not driven on violation");
	a_latch_hold: assert property (ce && s.len && s.limit_function_flag && !cfg_wr &&
		!mask_rd |=> s.limit_function_flag) else $error("latched flag dropped");
	a_limit_priority: assert property (ce && s.en[monitor_pkg::EN_SHUNT_OVER] &&
		shunt_done && !cfg_wr && !mask_rd && $signed(conv_data) > $signed(s.limit) |=>
		s.limit_function_flag) else $error("priority limit missed");

	c_load: cover property (ce && load && mode == 3'h7);
	c_alert: cover property (ce && cmp_evt && viol);
	c_wake: cover property (s.state == S_WAKE ##1 s.start);
endmodule : monitor_core
`default_nettype wire

//--- front_end_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the converter: answers each start after a short or a long conversion
module front_end_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic conv_start,
	input wire logic conv_chan,
	input wire logic front_end_on,
	input wire logic slow,
	input wire logic wobble,
	input wire logic [15:0] shunt_val,
	input wire logic [15:0] bus_val,
	output logic conv_done,
	output logic [15:0] conv_data
);
	// ---------------------------------------------------------------
	// conversion timing and sample data
	// ---------------------------------------------------------------
	int left;
	logic chan_q;
	logic [1:0] odd_q;
	logic [15:0] last_q;
	logic [15:0] sample;
	// wobble alternates +0/+2 per channel so only a true average lands on base+1
	assign sample = (chan_q ? bus_val : shunt_val) +
		((wobble && odd_q[chan_q]) ? 16'h0002 : 16'h0000);
	always_ff @(posedge clk) begin
		conv_done <= 1'b0;
		// data is only meaningful with done, so it never holds the last sample
		conv_data <= ~last_q;
		if (rst) begin
			left <= 0;
			odd_q <= 2'h0;
			last_q <= 16'h0000;
		end else if (conv_start && front_end_on) begin
			left <= slow ? 40 : 3;
			chan_q <= conv_chan;
		end else if (left == 1) begin
			left <= 0;
			conv_done <= 1'b1;
			conv_data <= sample;
			last_q <= sample;
			odd_q[chan_q] <= ~odd_q[chan_q];
		end else if (left > 1) begin
			left <= left - 1;
		end
	end
endmodule : front_end_model
`default_nettype wire

//--- conversion_sequencer_alert_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
	$display("[ERR] %0t got %h want %h", $time, got, exp); end end
module conversion_sequencer_alert_tb;
	// ---------------------------------------------------------------
	// clocks, stimulus and monitors
	// ---------------------------------------------------------------
	logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_rst = 1'b1, ce = 1'b1;
	logic req_valid = 1'b0, req_write = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [15:0] req_wdata = 16'h0000, shunt_val = 16'h03e8, bus_val = 16'h2710;
	logic req_ready, rsp_valid, conv_done, conv_start, conv_chan, front_end_on, alert_o, alert_oe;
	logic [15:0] rsp_rdata, conv_data;
	logic [2:0] conv_time, ct_shunt = 3'h0, ct_bus = 3'h0;
	logic slow = 1'b0, wobble = 1'b0, cont_chk = 1'b0, done_q = 1'b0, chan_q = 1'b0;
	int failures = 0, samples_checked = 0, starts0 = 0, starts1 = 0, dones = 0;
	always #50 clk = ~clk;
	always #6 link_clk = ~link_clk;
	monitor_core DUT (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk), .link_rst(link_rst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
		.conv_chan(conv_chan), .conv_time(conv_time), .front_end_on(front_end_on),
		.alert_o(alert_o),
		.alert_oe(alert_oe));
	front_end_model fe (.clk(clk), .rst(rst), .conv_start(conv_start), .conv_chan(conv_chan),
		.front_end_on(front_end_on), .slow(slow), .wobble(wobble), .shunt_val(shunt_val),
		.bus_val(bus_val), .conv_done(conv_done), .conv_data(conv_data));
	// in a running set every done must be followed at once by the other channel's start
	always @(posedge clk) begin
		if (conv_start) begin
			if (conv_chan) starts1++;
			else starts0++;
		end
		if (conv_done) dones++;
		if (cont_chk && done_q) `CHK({conv_start, conv_chan}, {1'b1, ~chan_q})
		done_q <= conv_done;
		if (conv_start) chan_q <= conv_chan;
		if (conv_start && conv_chan) ct_bus <= conv_time;
		if (conv_start && !conv_chan) ct_shunt <= conv_time;
	end
	// ---------------------------------------------------------------
	// register link tasks
	// ---------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		@(posedge link_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do @(posedge link_clk); while (req_ready !== 1'b1 && ++n < 200);
		req_valid <= 1'b0;
		do @(posedge link_clk); while ((w ? req_ready : rsp_valid) !== 1'b1 && ++n < 200);
		q = rsp_rdata;
		if (n >= 200) begin
			failures++;
			summarize();
		end
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] x;
		xfer(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		xfer(1'b0, a, 16'h0000, q);
	endtask : rd
	// flags and alert settle within a few cycles of the last done
	task automatic wait_dones(input int k);
		int t, n;
		t = dones + k;
		n = 0;
		while (dones < t && n++ < 5000) @(posedge clk);
		if (n >= 5000) begin
			failures++;
			summarize();
		end
		repeat (3) @(posedge clk);
	endtask : wait_dones
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	logic [15:0] am [11] = '{16'h8000, 16'h8000, 16'h4000, 16'h4000, 16'h2000, 16'h1000,
		16'h0800, 16'h0800, 16'hc000, 16'h8002, 16'h0400};
	logic [15:0] al [11] = '{16'h01f4, 16'h07d0, 16'h07d0, 16'h01f4, 16'h1388, 16'h4e20,
		16'h00c8, 16'h07d0, 16'h07d0, 16'h01f4, 16'h0000};
	logic [10:0] eo = 11'b10001110101;
	logic [10:0] ea = 11'b01001110101;
	initial begin
		logic [15:0] q;
		int s0, s1, n;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge link_clk);
		link_rst <= 1'b0;
		rd(monitor_pkg::REG_CONFIG, q);
		`CHK(q, monitor_pkg::CONFIG_RESET)
		rd(monitor_pkg::REG_MASK, q);
		`CHK(q, 16'h0000)
		wr(monitor_pkg::REG_SHUNT, 16'h1234);
		rd(monitor_pkg::REG_SHUNT, q);
		`CHK(q, 16'h0000)
		rd(8'h20, q);
		`CHK(q, 16'h0000)
		`CHK(starts0 + starts1, 0)
		// single shot with calibration still unloaded, distinct conversion-time codes
		wr(monitor_pkg::REG_CONFIG, 16'h01a3);
		wait_dones(2);
		rd(monitor_pkg::REG_CURRENT, q);
		`CHK(q, 16'h0000)
		rd(monitor_pkg::REG_POWER, q);
		`CHK(q, 16'h0000)
		rd(monitor_pkg::REG_BUS, q);
		`CHK(q, 16'h2710)
		rd(monitor_pkg::REG_MASK, q);
		`CHK(q[4:3], 2'h1)
		rd(monitor_pkg::REG_MASK, q);
		`CHK(q[3], 1'b0)
		repeat (60) @(posedge clk);
		`CHK(starts0 + starts1, 2)
		`CHK({ct_bus, ct_shunt}, {3'h6, 3'h4})
		// every single-shot mode, one set each
		wr(monitor_pkg::REG_CAL, 16'h0800);
		for (int m = 1; m <= 3; m++) begin
			s0 = starts0;
			s1 = starts1;
			wr(monitor_pkg::REG_CONFIG, 16'(m));
			wait_dones(m == 3 ? 2 : 1);
			`CHK({starts0 - s0, starts1 - s1}, {32'(m != 2), 32'(m != 1)})
		end
		rd(monitor_pkg::REG_CURRENT, q);
		`CHK(q, 16'h03e8)
		rd(monitor_pkg::REG_POWER, q);
		`CHK(q, 16'h01f4)
		// power-down keeps the flag and the registers
		wr(monitor_pkg::REG_CONFIG, 16'h0000);
		`CHK(front_end_on, 1'b0)
		rd(monitor_pkg::REG_MASK, q);
		`CHK(q[3], 1'b1)
		wr(monitor_pkg::REG_LIMIT, 16'h5a5a);
		rd(monitor_pkg::REG_LIMIT, q);
		`CHK(q, 16'h5a5a)
		wr(monitor_pkg::REG_CONFIG, 16'h0007);
		s0 = starts0 + starts1;
		n = 0;
		while (starts0 + starts1 == s0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		`CHK(n inside {[390:410]}, 1'b1)
		// averaging over four sets with reads going on
		@(posedge clk);
		wobble <= 1'b1;
		wr(monitor_pkg::REG_CONFIG, 16'h0207);
		wait_dones(1);
		cont_chk <= 1'b1;
		wait_dones(8);
		for (int i = 0; i < 6; i++) begin
			rd(monitor_pkg::REG_SHUNT, q);
			`CHK(q, 16'h03e9)
		end
		rd(monitor_pkg::REG_BUS, q);
		`CHK(q, 16'h2711)
		rd(monitor_pkg::REG_CURRENT, q);
		`CHK(q, 16'h03e9)
		@(posedge clk);
		cont_chk <= 1'b0;
		wobble <= 1'b0;
		// each limit function, priority, polarity and ready sharing
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			slow <= i[0];
			wr(monitor_pkg::REG_MASK, am[i]);
			wr(monitor_pkg::REG_LIMIT, al[i]);
			wr(monitor_pkg::REG_CONFIG, 16'h0003);
			wait_dones(2);
			`CHK(alert_oe, eo[i])
			rd(monitor_pkg::REG_MASK, q);
			`CHK(q[4:3], {ea[i], 1'b1})
		end
		`CHK(alert_o, 1'b0)
		// latched alert survives a clean sample until the mask read
		wr(monitor_pkg::REG_MASK, 16'h8001);
		wr(monitor_pkg::REG_LIMIT, 16'h01f4);
		wr(monitor_pkg::REG_CONFIG, 16'h0007);
		wait_dones(2);
		`CHK(alert_oe, 1'b1)
		shunt_val <= 16'h0064;
		wait_dones(4);
		`CHK(alert_oe, 1'b1)
		rd(monitor_pkg::REG_MASK, q);
		`CHK(q[4], 1'b1)
		wait_dones(4);
		`CHK(alert_oe, 1'b0)
		summarize();
	end
endmodule : conversion_sequencer_alert_tb
`default_nettype wire
